// *** pkg/intc_cfg.svh ***
// Constants for the priority interrupt controller: register map, fields, reset values
`ifndef INTC_CFG_SVH
`define INTC_CFG_SVH

// Register indices; byte address is four times the index
`define INTC_IDX_PRIO0       6'h00
`define INTC_IDX_PRIO1       6'h01
`define INTC_IDX_PRIO2       6'h02
`define INTC_IDX_PRIO3       6'h03
`define INTC_IDX_PRIO4       6'h04
`define INTC_IDX_VBASE       6'h05
`define INTC_IDX_FMATCH0     6'h06
`define INTC_IDX_FLOW0       6'h07
`define INTC_IDX_FHIGH0      6'h08
`define INTC_IDX_FMATCH1     6'h09
`define INTC_IDX_FLOW1       6'h0a
`define INTC_IDX_FHIGH1      6'h0b
`define INTC_IDX_PEND_LOW    6'h0c
`define INTC_IDX_PEND_MID    6'h0d
`define INTC_IDX_PEND_HIGH   6'h0e
`define INTC_IDX_CONTROL     6'h12
`define INTC_IDX_EVT_STATUS  6'h13
`define INTC_IDX_EVT_MASK    6'h14

// Writable bits of the priority, vector base and fast-channel registers; reserved fields read zero
`define INTC_PRIO0_WMASK     16'hc3ff
`define INTC_PRIO1_WMASK     16'hfcff
`define INTC_PRIO2_WMASK     16'hf3ff
`define INTC_PRIO3_WMASK     16'hfff0
`define INTC_PRIO4_WMASK     16'h00ff
`define INTC_VBASE_WMASK     16'h3fff
`define INTC_FMATCH_WMASK    16'h003f
`define INTC_FHIGH_WMASK     16'h001f
`define INTC_REG_RESET       16'h0000

// Source layout
`define INTC_NUM_SRC         46
`define INTC_NUM_FIXED       6
`define INTC_FIXED_LEVEL     2'h3
`define INTC_FIELDS_PER_REG  8
// Sources whose programmable range is levels 1..3 rather than 0..2
`define INTC_SRC_HIGH_RANGE  46'h0000_0000_07c0
`define INTC_FAST_LEVEL      2'h2

// Pending register layout
`define INTC_PEND_LOW_LSB    2
`define INTC_PEND_MID_LSB    17
`define INTC_PEND_HIGH_LSB   33
`define INTC_PEND_LOW_FILL   1'h1
`define INTC_PEND_HIGH_FILL  3'h7

// Event status bits
`define INTC_EVT_REQUEST     0
`define INTC_EVT_FAST        1
`define INTC_EVT_WAKE        2
`define INTC_EVT_WIDTH       3

`endif

// *** pkg/intc_pkg.sv ***
// Shared types for the priority interrupt controller
package intc_pkg;
	typedef logic [1:0]  level_t;
	typedef logic [5:0]  vec_num_t;
	typedef logic [15:0] word_t;
	typedef logic [20:0] vec_addr_t;
endpackage

// *** src/lowest_set_encoder.sv ***
// Finds the lowest-numbered active request in one priority level
`timescale 1ns/1ns
module lowest_set_encoder #(
	parameter int WIDTH = 46
) (
	input  wire logic [WIDTH-1:0] req,
	output logic                  found,
	output intc_pkg::vec_num_t    index
);
	// Scan from the top so the lowest set bit is the last to land
	always_comb
	begin
		found = 1'b0;
		index = '0;
		for (int i = WIDTH - 1; i >= 0; i--)
		begin
			if (req[i])
			begin
				found = 1'b1;
				index = intc_pkg::vec_num_t'(i);
			end
		end
	end
endmodule // lowest_set_encoder

// *** src/priority_interrupt_controller.sv ***
// Priority interrupt controller: APB registers, arbitration, vector generation, wake
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
`include "intc_cfg.svh"

module priority_interrupt_controller #(
	parameter int NUM_SRC = `INTC_NUM_SRC
) (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [7:0]                paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic [NUM_SRC-1:0]        irq_src,
	input  wire logic [1:0]                core_mask,
	input  wire logic                      low_power,
	output logic                           core_irq_req,
	output intc_pkg::level_t               core_irq_level,
	output intc_pkg::vec_num_t             core_vec_num,
	output intc_pkg::vec_addr_t            core_vec_addr,
	output logic                           core_fast,
	output logic                           core_fast_chan,
	output logic                           wake_req,
	output logic                           irq
);
	////////////////////////////////////////////////////////////////////////////////
	// Register storage
	intc_pkg::word_t                  prio_q [0:4];
	intc_pkg::word_t                  vbase_q;
	intc_pkg::word_t                  fmatch_q [0:1];
	intc_pkg::word_t                  flow_q [0:1];
	intc_pkg::word_t                  fhigh_q [0:1];
	logic [`INTC_EVT_WIDTH-1:0]       evt_status_q;
	logic [`INTC_EVT_WIDTH-1:0]       evt_mask_q;
	logic [NUM_SRC-1:0]               wake_en_q;
	logic                             low_power_q;

	logic                             wr_en;
	logic                             rd_en;
	logic [5:0]                       idx;
	logic                             mapped;
	intc_pkg::word_t                  rd_word;

	logic [NUM_SRC-1:0]               src_en;
	intc_pkg::level_t                 src_lvl [0:NUM_SRC-1];
	logic [NUM_SRC-1:0]               lvl_req [0:3];
	logic [3:0]                       lvl_found;
	intc_pkg::vec_num_t               lvl_idx [0:3];
	logic [NUM_SRC-1:0]               pend;
	// Sources whose codes map straight onto levels one to three
	localparam logic [NUM_SRC-1:0]    HIGH_RANGE = NUM_SRC'(`INTC_SRC_HIGH_RANGE);

	logic                             sel_valid;
	intc_pkg::level_t                 sel_level;
	intc_pkg::vec_num_t               sel_num;
	logic                             hit0;
	logic                             hit1;
	logic                             sel_fast;
	logic                             sel_chan;
	intc_pkg::vec_addr_t              sel_addr;
	logic                             wake_d;
	logic [`INTC_EVT_WIDTH-1:0]       evt_set;
	logic [`INTC_EVT_WIDTH-1:0]       evt_clr;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Writable bits per register; reserved bits never store
	function automatic intc_pkg::word_t wmask(input logic [5:0] i);
		unique case (i)
			`INTC_IDX_PRIO0: wmask = `INTC_PRIO0_WMASK;
			`INTC_IDX_PRIO1: wmask = `INTC_PRIO1_WMASK;
			`INTC_IDX_PRIO2: wmask = `INTC_PRIO2_WMASK;
			`INTC_IDX_PRIO3: wmask = `INTC_PRIO3_WMASK;
			default: wmask = `INTC_PRIO4_WMASK;
		endcase
	endfunction

	// Field 00 disables; other codes step upward from the source's floor
	function automatic intc_pkg::level_t field_level(input logic [1:0] f, input logic hi);
		field_level = hi ? f : intc_pkg::level_t'(f - 2'h1);
	endfunction

	// Mask code c permits every level not below c
	function automatic logic permitted(input intc_pkg::level_t l, input logic [1:0] c);
		permitted = (l >= c);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, error on unmapped index
	assign idx     = paddr[7:2];
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign mapped  = (idx <= `INTC_IDX_PEND_HIGH) || (idx == `INTC_IDX_CONTROL)
		|| (idx == `INTC_IDX_EVT_STATUS) || (idx == `INTC_IDX_EVT_MASK);
	assign pslverr = psel && penable && !mapped;

	// Priority registers; unused fields stay zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < 5; i++)
				prio_q[i] <= `INTC_REG_RESET;
		end
		else if (wr_en && idx <= `INTC_IDX_PRIO4)
		begin
			prio_q[idx[2:0]] <= pwdata[15:0] & wmask(idx);
		end
	end

	// Vector base and both fast channels
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			vbase_q <= `INTC_REG_RESET;
			for (int c = 0; c < 2; c++)
			begin
				fmatch_q[c] <= `INTC_REG_RESET;
				flow_q[c]   <= `INTC_REG_RESET;
				fhigh_q[c]  <= `INTC_REG_RESET;
			end
		end
		else if (wr_en)
		begin
			unique case (idx)
				`INTC_IDX_VBASE:   vbase_q     <= pwdata[15:0] & `INTC_VBASE_WMASK;
				`INTC_IDX_FMATCH0: fmatch_q[0] <= pwdata[15:0] & `INTC_FMATCH_WMASK;
				`INTC_IDX_FLOW0:   flow_q[0]   <= pwdata[15:0];
				`INTC_IDX_FHIGH0:  fhigh_q[0]  <= pwdata[15:0] & `INTC_FHIGH_WMASK;
				`INTC_IDX_FMATCH1: fmatch_q[1] <= pwdata[15:0] & `INTC_FMATCH_WMASK;
				`INTC_IDX_FLOW1:   flow_q[1]   <= pwdata[15:0];
				`INTC_IDX_FHIGH1:  fhigh_q[1]  <= pwdata[15:0] & `INTC_FHIGH_WMASK;
				default:           ;
			endcase
		end
	end

	// Event mask register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			evt_mask_q <= '0;
		else if (wr_en && idx == `INTC_IDX_EVT_MASK)
			evt_mask_q <= pwdata[`INTC_EVT_WIDTH-1:0];
	end

	// Read mux; pending registers pad with ones as the layout demands
	always_comb
	begin
		rd_word = '0;
		unique case (idx)
			`INTC_IDX_VBASE:     rd_word = vbase_q;
			`INTC_IDX_FMATCH0:   rd_word = fmatch_q[0];
			`INTC_IDX_FLOW0:     rd_word = flow_q[0];
			`INTC_IDX_FHIGH0:    rd_word = fhigh_q[0];
			`INTC_IDX_FMATCH1:   rd_word = fmatch_q[1];
			`INTC_IDX_FLOW1:     rd_word = flow_q[1];
			`INTC_IDX_FHIGH1:    rd_word = fhigh_q[1];
			`INTC_IDX_PEND_LOW:
				rd_word = {pend[`INTC_PEND_MID_LSB-1:`INTC_PEND_LOW_LSB],
					`INTC_PEND_LOW_FILL};
			`INTC_IDX_PEND_MID:
				rd_word = pend[`INTC_PEND_HIGH_LSB-1:`INTC_PEND_MID_LSB];
			`INTC_IDX_PEND_HIGH:
				rd_word = {`INTC_PEND_HIGH_FILL,
					pend[NUM_SRC-1:`INTC_PEND_HIGH_LSB]};
			`INTC_IDX_CONTROL:
				rd_word = {core_irq_req, core_irq_level, core_fast, core_fast_chan,
					5'h00, core_vec_num};
			`INTC_IDX_EVT_STATUS: rd_word = 16'(evt_status_q);
			`INTC_IDX_EVT_MASK:   rd_word = 16'(evt_mask_q);
			default:
			begin
				if (idx <= `INTC_IDX_PRIO4)
					rd_word = prio_q[idx[2:0]];
			end
		endcase
	end

	// Read data registered at the edge that ends the setup phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= '0;
		else if (psel && !penable && !pwrite)
			prdata <= {16'h0000, rd_word};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-source enable and level decode
	always_comb
	begin
		for (int s = 0; s < NUM_SRC; s++)
		begin
			if (s < `INTC_NUM_FIXED)
			begin
				src_en[s]  = 1'b1;
				src_lvl[s] = `INTC_FIXED_LEVEL;
			end
			else
			begin
				src_en[s]  = prio_q[(s - `INTC_NUM_FIXED) / `INTC_FIELDS_PER_REG]
					[2 * ((s - `INTC_NUM_FIXED) % `INTC_FIELDS_PER_REG) +: 2] != 2'h0;
				src_lvl[s] = field_level(
					prio_q[(s - `INTC_NUM_FIXED) / `INTC_FIELDS_PER_REG]
					[2 * ((s - `INTC_NUM_FIXED) % `INTC_FIELDS_PER_REG) +: 2],
					HIGH_RANGE[s]);
			end
		end
	end

	assign pend = irq_src & src_en;

	// Split pending sources into one vector per level
	always_comb
	begin
		for (int l = 0; l < 4; l++)
			for (int s = 0; s < NUM_SRC; s++)
				lvl_req[l][s] = pend[s] && src_lvl[s] == 2'(l);
	end

	// One lowest-number encoder per level
	for (genvar g = 0; g < 4; g++)
	begin : g_level
		lowest_set_encoder #(
			.WIDTH (NUM_SRC)
		) u_enc (
			.req   (lvl_req[g]),
			.found (lvl_found[g]),
			.index (lvl_idx[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Arbitration: highest permitted level wins; the core raises its mask while
	// servicing, so only levels not below the raised mask code can nest on top
	always_comb
	begin
		sel_valid = 1'b0;
		sel_level = '0;
		sel_num   = '0;
		for (int l = 0; l < 4; l++)
		begin
			if (lvl_found[l] && permitted(2'(l), core_mask))
			begin
				sel_valid = 1'b1;
				sel_level = 2'(l);
				sel_num   = lvl_idx[l];
			end
		end
	end

	// Fast recognition happens here so the core receives the final address
	assign hit0     = sel_num == fmatch_q[0][5:0];
	assign hit1     = sel_num == fmatch_q[1][5:0];
	assign sel_fast = sel_valid && sel_level == `INTC_FAST_LEVEL && (hit0 || hit1);
	assign sel_chan = !hit0; // Channel 0 wins when both match

	// Vector address choice
	always_comb
	begin
		if (sel_fast)
			sel_addr = {fhigh_q[sel_chan][4:0], flow_q[sel_chan]};
		else
			sel_addr = 21'({vbase_q[13:0], sel_num});
	end

	// Registered outputs toward the core; the core decides fast handling
	// from the fetched opcode, which is outside this block
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core_irq_req   <= 1'b0;
			core_irq_level <= '0;
			core_vec_num   <= '0;
			core_vec_addr  <= '0;
			core_fast      <= 1'b0;
			core_fast_chan <= 1'b0;
		end
		else
		begin
			core_irq_req   <= sel_valid;
			core_irq_level <= sel_level;
			core_vec_num   <= sel_num;
			core_vec_addr  <= sel_addr;
			core_fast      <= sel_fast;
			core_fast_chan <= sel_fast && sel_chan;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wake: enables are frozen on entry so later programming cannot wake
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			low_power_q <= 1'b0;
			wake_en_q   <= '0;
			wake_req    <= 1'b0;
		end
		else
		begin
			low_power_q <= low_power;
			if (low_power && !low_power_q)
				wake_en_q <= src_en;
			wake_req <= wake_d;
		end
	end

	assign wake_d = low_power && low_power_q && |(irq_src & wake_en_q);

	////////////////////////////////////////////////////////////////////////////////
	// Event status: write one to clear, a new event in the same cycle wins
	assign evt_set = {wake_d && !wake_req, sel_fast && !core_fast, sel_valid && !core_irq_req};
	assign evt_clr = (wr_en && idx == `INTC_IDX_EVT_STATUS) ?
		pwdata[`INTC_EVT_WIDTH-1:0] : '0;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			evt_status_q <= '0;
		else
			evt_status_q <= (evt_status_q & ~evt_clr) | evt_set;
	end

	assign irq = |(evt_status_q & evt_mask_q);
endmodule // priority_interrupt_controller

// *** verification/core_model.sv ***
// Behavioural core: mask bits and start of fast handling
`timescale 1ns/1ns
module core_model (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [1:0]  mask_cmd,
	input wire logic        core_irq_req,
	input wire logic        core_fast,
	input wire logic        sub_jump,
	output logic [1:0]      core_mask,
	output logic            fast_begun
);
	// Mask bits follow the running program's status word
	assign core_mask = mask_cmd;
	// A subroutine jump at the vector falls back to normal handling
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			fast_begun <= 1'b0;
		else
			fast_begun <= core_irq_req & core_fast & !sub_jump;
	end
endmodule // core_model

// *** verification/intc_props.sv ***
// Concurrent checks on the interrupt controller ports
`timescale 1ns/1ns
module intc_props #(
	parameter int NUM_SRC = 46
) (
	input wire logic                      pclk,
	input wire logic                      presetn,
	input wire logic                      psel,
	input wire logic                      penable,
	input wire logic                      pwrite,
	input wire logic [7:0]                paddr,
	input wire logic [31:0]               pwdata,
	input wire logic [31:0]               prdata,
	input wire logic                      pready,
	input wire logic                      pslverr,
	input wire logic [NUM_SRC-1:0]        irq_src,
	input wire logic [1:0]                core_mask,
	input wire logic                      low_power,
	input wire logic                      core_irq_req,
	input wire intc_pkg::level_t          core_irq_level,
	input wire intc_pkg::vec_num_t        core_vec_num,
	input wire intc_pkg::vec_addr_t       core_vec_addr,
	input wire logic                      core_fast,
	input wire logic                      core_fast_chan,
	input wire logic                      wake_req,
	input wire logic                      irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [NUM_SRC-1:0] src_q;
	////////////////////////////////////////////////////////////////
	// Requests seen one edge ago, to tie the winner to a real source
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			src_q <= '0;
		else
			src_q <= irq_src;
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	////////////////////////////////////////////////////////////////
	a_access_ready: assert property (s_setup ##1 s_access |-> pready)
		else $error("access phase without ready");
	a_unmapped_err: assert property (s_access ##0 (paddr[7:2] == 6'h0f) |-> pslverr)
		else $error("unmapped access not refused");
	a_read_upper: assert property (s_access ##0 !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	a_mask_gates: assert property (core_irq_req |-> core_irq_level >= $past(core_mask))
		else $error("masked level presented");
	a_idle_no_req: assert property (!$past(|irq_src) |-> !core_irq_req)
		else $error("request with nothing pending");
	a_fast_level: assert property (core_fast |-> core_irq_req && core_irq_level == 2'h2)
		else $error("fast request not at level two");
	a_normal_vector: assert property (core_irq_req && !core_fast |->
		core_vec_addr[5:0] == core_vec_num)
		else $error("vector number missing from address");
	a_winner_pending: assert property (core_irq_req |-> src_q[core_vec_num])
		else $error("winner was not requesting");
	a_source_zero: assert property ($past(irq_src[0]) && $past(presetn) |->
		core_irq_req && core_vec_num == 6'd0)
		else $error("top source not presented");
	a_wake_sleep: assert property (wake_req |-> $past(low_power))
		else $error("wake outside low power");
endmodule // intc_props
bind priority_interrupt_controller intc_props #(.NUM_SRC(NUM_SRC)) u_props (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_src(irq_src),
	.core_mask(core_mask), .low_power(low_power), .core_irq_req(core_irq_req),
	.core_irq_level(core_irq_level), .core_vec_num(core_vec_num), .core_vec_addr(core_vec_addr),
	.core_fast(core_fast), .core_fast_chan(core_fast_chan), .wake_req(wake_req), .irq(irq));

// *** verification/priority_interrupt_controller_tb_top.sv ***
// Self-checking bench for the priority interrupt controller
`timescale 1ns/1ns
`include "intc_cfg.svh"
module priority_interrupt_controller_tb_top;
	logic pclk, presetn, psel, penable, pwrite, low_power, er, sub_jump;
	logic [7:0] paddr;
	logic [31:0] pwdata, rd, prdata;
	logic [45:0] irq_src;
	logic [1:0] mask_cmd, core_mask;
	logic [15:0] wm [12];
	logic pready, pslverr, core_irq_req, core_fast, core_fast_chan, wake_req, irq, fast_begun;
	intc_pkg::level_t core_irq_level;
	intc_pkg::vec_num_t core_vec_num;
	intc_pkg::vec_addr_t core_vec_addr;
	int err_total, num_checks, i, c, m;
	priority_interrupt_controller uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq_src(irq_src), .core_mask(core_mask),
		.low_power(low_power), .core_irq_req(core_irq_req), .core_irq_level(core_irq_level),
		.core_vec_num(core_vec_num), .core_vec_addr(core_vec_addr), .core_fast(core_fast),
		.core_fast_chan(core_fast_chan), .wake_req(wake_req), .irq(irq));
	core_model u_core (.pclk(pclk), .presetn(presetn), .mask_cmd(mask_cmd),
		.core_irq_req(core_irq_req), .core_fast(core_fast), .sub_jump(sub_jump),
		.core_mask(core_mask), .fast_begun(fast_begun));
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////
	task final_report;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
		// Back on a rising edge so the next drive lands on it
		@(posedge pclk);
	endtask
	// One APB transfer; waits on ready under a bound
	task apb(input logic wr, input logic [5:0] idx, input logic [15:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {16'h0000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (n == 20)
		begin
			err_total++;
			final_report();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rchk(input logic [5:0] idx, input logic [15:0] exp);
		apb(1'b0, idx, 16'h0000);
		chk(rd, {16'h0000, exp});
	endtask
	// Core outputs lag their inputs by one edge
	task settle;
		repeat (2) @(posedge pclk);
		#1;
	endtask
	task core_chk(input logic [31:0] exp);
		settle();
		chk({core_irq_req, core_irq_level, core_fast, core_fast_chan, core_vec_num,
			core_vec_addr}, exp);
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20000) @(posedge pclk);
		err_total++;
		final_report();
	end
	initial
	begin
		{psel, penable, pwrite, presetn, low_power, sub_jump, paddr, pwdata, irq_src, mask_cmd} = '0;
		wm = '{`INTC_PRIO0_WMASK, `INTC_PRIO1_WMASK, `INTC_PRIO2_WMASK, `INTC_PRIO3_WMASK,
			`INTC_PRIO4_WMASK, `INTC_VBASE_WMASK, `INTC_FMATCH_WMASK, 16'hffff,
			`INTC_FHIGH_WMASK, `INTC_FMATCH_WMASK, 16'hffff, `INTC_FHIGH_WMASK};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 15; i++)
			rchk(6'(i), i == 12 ? 16'h0001 : i == 14 ? 16'he000 : 16'h0000);
		for (i = 0; i < 12; i++)
		begin
			apb(1'b1, 6'(i), 16'hffff);
			rchk(6'(i), wm[i]);
			apb(1'b1, 6'(i), 16'h0000);
		end
		apb(1'b0, 6'h0f, 16'h0000);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, `INTC_IDX_PEND_LOW, 16'hffff);
		rchk(`INTC_IDX_PEND_LOW, 16'h0001);
		// Two sources tie at level two; lower number must win
		apb(1'b1, `INTC_IDX_VBASE, 16'h0123);
		apb(1'b1, `INTC_IDX_PRIO0, 16'h000a);
		irq_src <= 46'h0c0;
		core_chk({1'b1, 2'h2, 2'b00, 6'd6, 1'b0, 14'h0123, 6'd6});
		rchk(`INTC_IDX_PEND_LOW, 16'h0061);
		irq_src <= 46'h0c1;
		mask_cmd <= 2'h2;
		core_chk({1'b1, 2'h3, 2'b00, 6'd0, 1'b0, 14'h0123, 6'd0});
		// Levels one to three against every mask code, level zero against codes 0 and 1
		irq_src <= 46'h040;
		for (c = 1; c < 4; c++)
			for (m = 0; m < 4; m++)
			begin
				apb(1'b1, `INTC_IDX_PRIO0, 16'(c));
				mask_cmd <= 2'(m);
				settle();
				chk({31'h0, core_irq_req}, 32'(c >= m));
			end
		apb(1'b1, `INTC_IDX_PRIO0, 16'h0000);
		apb(1'b1, `INTC_IDX_PRIO1, 16'h0001);
		irq_src <= 46'h4000;
		mask_cmd <= 2'h0;
		core_chk({1'b1, 2'h0, 2'b00, 6'd14, 1'b0, 14'h0123, 6'd14});
		mask_cmd <= 2'h1;
		settle();
		chk({31'h0, core_irq_req}, 32'h0);
		// Both fast channels set up by software
		mask_cmd <= 2'h0;
		apb(1'b1, `INTC_IDX_PRIO1, 16'h0000);
		apb(1'b1, `INTC_IDX_PRIO0, 16'h0028);
		apb(1'b1, `INTC_IDX_FMATCH0, 16'h0007);
		apb(1'b1, `INTC_IDX_FLOW0, 16'hbeef);
		apb(1'b1, `INTC_IDX_FHIGH0, 16'h0015);
		apb(1'b1, `INTC_IDX_FMATCH1, 16'h0008);
		apb(1'b1, `INTC_IDX_FLOW1, 16'h1234);
		apb(1'b1, `INTC_IDX_FHIGH1, 16'h000a);
		irq_src <= 46'h080;
		core_chk({1'b1, 2'h2, 1'b1, 1'b0, 6'd7, 5'h15, 16'hbeef});
		// Control word: request, level two, fast on channel 0, vector 7
		rchk(`INTC_IDX_CONTROL, 16'hd007);
		settle();
		chk({31'h0, fast_begun}, 32'h1);
		// A subroutine jump at the vector keeps the core on normal handling
		sub_jump <= 1'b1;
		settle();
		chk({31'h0, fast_begun}, 32'h0);
		sub_jump <= 1'b0;
		irq_src <= 46'h100;
		core_chk({1'b1, 2'h2, 1'b1, 1'b1, 6'd8, 5'h0a, 16'h1234});
		// Matching vector at level three stays normal
		apb(1'b1, `INTC_IDX_PRIO0, 16'h000c);
		irq_src <= 46'h080;
		core_chk({1'b1, 2'h3, 2'b00, 6'd7, 1'b0, 14'h0123, 6'd7});
		// Event status: masked, unmasked, cleared
		irq_src <= '0;
		apb(1'b1, `INTC_IDX_EVT_STATUS, 16'h0007);
		irq_src <= 46'h080;
		settle();
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `INTC_IDX_EVT_MASK, 16'h0001);
		settle();
		chk({31'h0, irq}, 32'h1);
		rchk(`INTC_IDX_EVT_STATUS, 16'h0001);
		irq_src <= '0;
		apb(1'b1, `INTC_IDX_EVT_STATUS, 16'h0001);
		settle();
		chk({31'h0, irq}, 32'h0);
		// Wake only for a source enabled before sleep
		low_power <= 1'b1;
		repeat (3) @(posedge pclk);
		irq_src <= 46'h080;
		settle();
		chk({31'h0, wake_req}, 32'h1);
		irq_src <= '0;
		low_power <= 1'b0;
		apb(1'b1, `INTC_IDX_PRIO0, 16'h0000);
		low_power <= 1'b1;
		apb(1'b1, `INTC_IDX_PRIO0, 16'h000c);
		irq_src <= 46'h080;
		settle();
		chk({31'h0, wake_req}, 32'h0);
		final_report();
	end
endmodule // priority_interrupt_controller_tb_top
